// ===== core/clock_divider.v
// Clock divider producing a one-cycle enable tick at clk/divisor
`timescale 1ns/1ps
module clock_divider #(
	parameter W = 8
) (
	input wire sys_clk,
	input wire rst_n,
	input wire ce,
	input wire run,
	input wire [W-1:0] divisor,
	output reg tick_r
);
	// Down counter
	reg [W-1:0] cnt_r;
	// Divisor of zero or one is treated as pass-through
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= {W{1'b0}};
			tick_r <= 1'b0;
		end else if (ce) begin
			if (!run) begin
				// Hold idle while the source is unavailable
				cnt_r <= {W{1'b0}};
				tick_r <= 1'b0;
			end else if (cnt_r == {W{1'b0}}) begin
				cnt_r <= (divisor > {{(W-1){1'b0}}, 1'b1}) ? divisor - {{(W-1){1'b0}}, 1'b1} : {W{1'b0}};
				tick_r <= 1'b1;
			end else begin
				cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
				tick_r <= 1'b0;
			end
		end
	end
endmodule // clock_divider

// ===== core/clock_power_wake_sequencer.v
// Clock source selection, loop control, power modes and wake sequencing
//
// Summary of operation
// R1 - Both loops off and unpowered after reset
// R2 - Loop output divider never below two
// R3 - Main loop: RC or oscillator; alternate: oscillator
// R4 - Derived clock picks source, optional divider
// R5 - Software sets USB loop to 48 MHz multiple
// R6 - RTC oscillator gives 1 Hz and 32k out
// R7 - Watchdog oscillator runs when watchdog enabled
// R8 - Wait 60 us then four cycles before resume
// R9 - Flash timer counts 100 us of RC cycles (code counts FLASH_CYC system clock cycles instead)
// R10 - Flash blocked until flash timer expires
// R11 - Software reconfigures loops after power-down wake
// R12 - Deep power-down keeps only RTC, reset logic
// R13 - Software option keeps 32k oscillator powered
// R14 - Deep power-down exits by reset or alarm
// R15 - Interrupt controller hands over wake mask
// R16 - Masked interrupt while stopped wakes the CPU
// R17 - Per-peripheral power switch under software
// R18 - Loop usable only when enabled and locked
`timescale 1ns/1ps
`include "clock_power_wake_defs.vh"
module clock_power_wake_sequencer #(
	parameter DIV_W = 8,
	parameter NIRQ = 32,
	parameter NPERIPH = 32,
	parameter CLK_MHZ = 100
) (
	input wire sys_clk,
	input wire rst_n,
	input wire ce,
	input wire main_loop_en,
	input wire alt_loop_en,
	input wire main_loop_lock,
	input wire alt_loop_lock,
	input wire main_loop_ref_osc,
	input wire [DIV_W-1:0] main_loop_out_div,
	input wire [DIV_W-1:0] alt_loop_out_div,
	input wire [1:0] clock_source_select,
	input wire [DIV_W-1:0] derived_div,
	input wire [1:0] clock_output_select,
	input wire rtc_1hz_in,
	input wire rtc_32k_in,
	input wire wdog_osc_in,
	input wire wdog_enable,
	input wire [NPERIPH-1:0] periph_power_req,
	input wire [1:0] sleep_mode,
	input wire sleep_enter,
	input wire keep_32k_in_dpd,
	input wire irc_was_source,
	input wire [NIRQ-1:0] wake_mask_in,
	input wire [NIRQ-1:0] irq_pending,
	input wire rtc_alarm,
	output reg main_loop_power_r,
	output reg alt_loop_power_r,
	output reg main_loop_ref_osc_r,
	output reg [DIV_W-1:0] main_loop_div_r,
	output reg [DIV_W-1:0] alt_loop_div_r,
	output reg [1:0] src_active_r,
	output reg derived_tick_r,
	output reg clock_output_pin_r,
	output reg rtc_1hz_r,
	output reg wdog_osc_run_r,
	output reg [NPERIPH-1:0] periph_power_r,
	output reg core_power_r,
	output reg osc32k_power_r,
	output reg clocks_stopped_r,
	output reg cpu_resume_r,
	output reg flash_ready_r,
	output reg wake_event_r
);
	// Start-up times converted to cycles as microseconds times CLK_MHZ, with no rounding
	localparam [31:0] IRC_START_CYC = (`IRC_START_US * CLK_MHZ + 32'h0000_0000);
	localparam [31:0] FLASH_CYC = (`FLASH_START_US * CLK_MHZ);
	// RC cycles making up the flash start-up time
	localparam [31:0] FLASH_IRC_CYC = `FLASH_START_US * `IRC_MHZ;
	// Sequencer states
	localparam [2:0] ST_RUN = 3'h0;
	localparam [2:0] ST_SLEEP = 3'h1;
	localparam [2:0] ST_DPD = 3'h2;
	localparam [2:0] ST_IRC_START = 3'h3;
	localparam [2:0] ST_SETTLE = 3'h4;

	// Clamp a divider to at least two
	function [DIV_W-1:0] clamp_div;
		input [DIV_W-1:0] d;
		begin
			clamp_div = (d < `DIV_MIN) ? `DIV_MIN : d;
		end
	endfunction

	reg [2:0] state_r; // Sequencer state
	reg [31:0] wait_r; // Start-up cycle counter
	reg [31:0] flash_r; // Flash wake-up timer
	reg [NIRQ-1:0] mask_r; // Captured wake mask
	reg [1:0] mode_r; // Mode being slept in
	reg [1:0] src_nxt; // Resolved clock source
	reg cko_nxt; // Clock output pin value
	wire div_tick; // Derived clock enable tick
	wire main_ok; // Main loop usable
	wire alt_ok; // Alternate loop usable

	// Loop usable only with power and lock
	assign main_ok = main_loop_power_r & main_loop_lock; // R18
	assign alt_ok = alt_loop_power_r & alt_loop_lock; // R18

	// Source resolution: an unusable loop falls back to the RC oscillator
	always @* begin
		src_nxt = `SRC_IRC;
		case (clock_source_select)
			`SRC_MAIN_OSC: src_nxt = `SRC_MAIN_OSC;
			`SRC_MAIN_LOOP: src_nxt = main_ok ? `SRC_MAIN_LOOP : `SRC_IRC; // R4 R18
			`SRC_ALT_LOOP: src_nxt = alt_ok ? `SRC_ALT_LOOP : `SRC_IRC; // R18
			default: src_nxt = `SRC_IRC;
		endcase
	end

	// Clock output pin routing
	always @* begin
		case (clock_output_select)
			`CKO_SYS: cko_nxt = div_tick; // R4
			`CKO_RTC32K: cko_nxt = rtc_32k_in; // R6
			`CKO_WDOG: cko_nxt = wdog_osc_in & wdog_enable; // R7
			default: cko_nxt = 1'b0;
		endcase
	end

	// Optional divider on the derived clock
	clock_divider #(
		.W(DIV_W)
	) i_clock_divider (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ce(ce),
		.run(clocks_stopped_r == 1'b0),
		.divisor(derived_div),
		.tick_r(div_tick)
	);

	// Loop control and clock routing registers
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			main_loop_power_r <= 1'b0; // R1
			alt_loop_power_r <= 1'b0; // R1
			main_loop_ref_osc_r <= 1'b0;
			main_loop_div_r <= `DIV_MIN;
			alt_loop_div_r <= `DIV_MIN;
			src_active_r <= `SRC_IRC;
			derived_tick_r <= 1'b0;
			clock_output_pin_r <= 1'b0;
			rtc_1hz_r <= 1'b0;
			wdog_osc_run_r <= 1'b0;
			periph_power_r <= {NPERIPH{1'b0}};
		end else if (ce) begin
			// Loops are lost in every sleep mode: deep sleep, power-down and deep power-down
			main_loop_power_r <= main_loop_en & ~clocks_stopped_r; // R1 R11
			alt_loop_power_r <= alt_loop_en & ~clocks_stopped_r; // R1 R11
			// Alternate loop has no reference choice; only the main one does
			main_loop_ref_osc_r <= main_loop_ref_osc; // R3
			main_loop_div_r <= clamp_div(main_loop_out_div); // R2
			alt_loop_div_r <= clamp_div(alt_loop_out_div); // R2
			src_active_r <= src_nxt; // R4
			derived_tick_r <= div_tick; // R4
			clock_output_pin_r <= cko_nxt;
			rtc_1hz_r <= rtc_1hz_in; // R6
			wdog_osc_run_r <= wdog_enable; // R7
			periph_power_r <= core_power_r ? periph_power_req : {NPERIPH{1'b0}}; // R17
		end
	end

	// Power mode and wake sequencer
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_RUN;
			wait_r <= 32'h0000_0000;
			flash_r <= 32'h0000_0000;
			mask_r <= {NIRQ{1'b0}};
			mode_r <= `MODE_RUN;
			core_power_r <= 1'b1;
			osc32k_power_r <= 1'b1;
			clocks_stopped_r <= 1'b0;
			cpu_resume_r <= 1'b1;
			flash_ready_r <= 1'b1;
			wake_event_r <= 1'b0;
		end else if (ce) begin
			wake_event_r <= 1'b0;
			// Flash timer runs only once awake; counting while asleep would open flash early
			if (!flash_ready_r && state_r != ST_SLEEP && state_r != ST_DPD) begin
				if (flash_r >= FLASH_CYC - 32'h0000_0001) begin
					flash_ready_r <= 1'b1; // R10
				end else begin
					flash_r <= flash_r + 32'h0000_0001; // R9
				end
			end
			case (state_r)
				ST_RUN: begin
					if (sleep_enter && sleep_mode != `MODE_RUN) begin
						mask_r <= wake_mask_in; // R15
						mode_r <= sleep_mode;
						// Stale count from the last wake must not carry over
						flash_r <= 32'h0000_0000; // R9
						clocks_stopped_r <= 1'b1;
						cpu_resume_r <= 1'b0;
						if (sleep_mode == `MODE_DEEP_PD) begin
							core_power_r <= 1'b0; // R12
							osc32k_power_r <= keep_32k_in_dpd; // R13
							flash_ready_r <= 1'b0;
							state_r <= ST_DPD;
						end else begin
							if (sleep_mode == `MODE_POWER_DOWN)
								flash_ready_r <= 1'b0; // R10
							state_r <= ST_SLEEP;
						end
					end
				end
				ST_SLEEP: begin
					// Level compare, no polling loop needed
					if ((irq_pending & mask_r) != {NIRQ{1'b0}}) begin
						wake_event_r <= 1'b1; // R16
						wait_r <= 32'h0000_0000;
						flash_r <= 32'h0000_0000; // R9
						if (mode_r == `MODE_POWER_DOWN && irc_was_source)
							state_r <= ST_IRC_START; // R8
						else
							state_r <= ST_SETTLE;
					end
				end
				ST_DPD: begin
					// Only the alarm wakes here; reset pin is rst_n itself
					if (rtc_alarm) begin
						wake_event_r <= 1'b1; // R14
						core_power_r <= 1'b1;
						osc32k_power_r <= 1'b1;
						wait_r <= 32'h0000_0000;
						flash_r <= 32'h0000_0000;
						state_r <= ST_IRC_START;
					end
				end
				ST_IRC_START: begin
					clocks_stopped_r <= 1'b0;
					if (wait_r >= IRC_START_CYC - 32'h0000_0001) begin
						wait_r <= 32'h0000_0000;
						state_r <= ST_SETTLE; // R8
					end else begin
						wait_r <= wait_r + 32'h0000_0001;
					end
				end
				ST_SETTLE: begin
					// Four oscillator cycles before code resumes from SRAM
					clocks_stopped_r <= 1'b0;
					if (wait_r >= `IRC_SETTLE_CYC - 32'h0000_0001) begin
						cpu_resume_r <= 1'b1; // R8
						mode_r <= `MODE_RUN;
						state_r <= ST_RUN;
					end else begin
						wait_r <= wait_r + 32'h0000_0001;
					end
				end
				default: state_r <= ST_RUN;
			endcase
		end
	end
endmodule // clock_power_wake_sequencer

// ===== inc/clock_power_wake_defs.vh
// Constants shared by the clock, power and wake sequencer
`ifndef CLOCK_POWER_WAKE_DEFS_VH
`define CLOCK_POWER_WAKE_DEFS_VH
`define CLK_PERIOD_PS 32'h0000_2710
`define IRC_START_US 32'h0000_003C
`define IRC_SETTLE_CYC 32'h0000_0004
`define FLASH_START_US 32'h0000_0064
`define IRC_MHZ 32'h0000_000C
`define DIV_MIN 8'h02
`define SRC_IRC 2'h0
`define SRC_MAIN_OSC 2'h1
`define SRC_MAIN_LOOP 2'h2
`define SRC_ALT_LOOP 2'h3
`define CKO_SYS 2'h0
`define CKO_RTC32K 2'h1
`define CKO_WDOG 2'h2
`define CKO_OFF 2'h3
`define MODE_RUN 2'h0
`define MODE_DEEP_SLEEP 2'h1
`define MODE_POWER_DOWN 2'h2
`define MODE_DEEP_PD 2'h3
`endif

// ===== verification/clock_power_wake_sequencer_assertions.sv
// Checker for the clock, power and wake sequencer
`timescale 1ns/1ps
module cpw_checker #(
	parameter DIV_W = 8
) (
	input wire sys_clk,
	input wire rst_n,
	input wire ce,
	input wire main_loop_en,
	input wire main_loop_lock,
	input wire [1:0] clock_source_select,
	input wire wdog_enable,
	input wire [1:0] sleep_mode,
	input wire rtc_alarm,
	input wire main_loop_power_r,
	input wire [DIV_W-1:0] main_loop_div_r,
	input wire [DIV_W-1:0] alt_loop_div_r,
	input wire [1:0] src_active_r,
	input wire wdog_osc_run_r,
	input wire core_power_r,
	input wire clocks_stopped_r,
	input wire cpu_resume_r,
	input wire flash_ready_r,
	input wire wake_event_r
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Loop stays dark while software leaves it off
	property p_loop_off; ce && !main_loop_en |=> !main_loop_power_r; endproperty
	a_loop_off: assert property (p_loop_off) else $error("loop powered while off");
	// Divide below two would break the duty cycle
	property p_div_min; main_loop_div_r >= 8'h02 && alt_loop_div_r >= 8'h02; endproperty
	a_div_min: assert property (p_div_min) else $error("loop divider below two");
	// Unlocked main loop never offered
	property p_src_lock; ce && clock_source_select == 2'h2 && !main_loop_lock |=> src_active_r != 2'h2; endproperty
	a_src_lock: assert property (p_src_lock) else $error("unlocked loop selected");
	// Watchdog oscillator follows its enable
	property p_wdog; ce && !clocks_stopped_r |=> wdog_osc_run_r == $past(wdog_enable); endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog oscillator wrong");
	// Flash stays blocked well past the wake event
	property p_flash; wake_event_r && !flash_ready_r |=> !flash_ready_r [*8]; endproperty
	a_flash: assert property (p_flash) else $error("flash opened early");
	// Core domain drops on deep power-down entry
	property p_dpd_pwr; $rose(clocks_stopped_r) && sleep_mode == 2'h3 |-> !core_power_r; endproperty
	a_dpd_pwr: assert property (p_dpd_pwr) else $error("core powered in deep power-down");
	// Only the alarm or reset leaves deep power-down
	property p_dpd_irq;
		clocks_stopped_r && sleep_mode == 2'h3 && !rtc_alarm && !$past(rtc_alarm) && !$past(rtc_alarm, 2)
		|=> !wake_event_r;
	endproperty
	a_dpd_irq: assert property (p_dpd_irq) else $error("deep power-down woke by interrupt");
	// Deep sleep resumes promptly after a wake
	property p_ds_resume; wake_event_r && sleep_mode == 2'h1 |-> ##[1:6] cpu_resume_r; endproperty
	a_ds_resume: assert property (p_ds_resume) else $error("deep sleep resume late");
endmodule // cpw_checker
bind clock_power_wake_sequencer cpw_checker #(.DIV_W(DIV_W)) i_cpw_checker (
	.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .main_loop_en(main_loop_en), .main_loop_lock(main_loop_lock),
	.clock_source_select(clock_source_select), .wdog_enable(wdog_enable), .sleep_mode(sleep_mode),
	.rtc_alarm(rtc_alarm), .main_loop_power_r(main_loop_power_r), .main_loop_div_r(main_loop_div_r),
	.alt_loop_div_r(alt_loop_div_r), .src_active_r(src_active_r), .wdog_osc_run_r(wdog_osc_run_r),
	.core_power_r(core_power_r), .clocks_stopped_r(clocks_stopped_r), .cpu_resume_r(cpu_resume_r),
	.flash_ready_r(flash_ready_r), .wake_event_r(wake_event_r)
);

// ===== verification/core_model.sv
// Processor side model: interrupt controller mask and interrupt lines
`timescale 1ns/1ps
module core_model (
	input wire sys_clk,
	input wire clocks_stopped_r,
	input wire fire,
	output reg [31:0] wake_mask_in,
	output reg [31:0] irq_pending
);
	// Mask valid only at entry; once stopped it turns to line 0, so a live-mask design wakes at once
	always_comb begin
		wake_mask_in = clocks_stopped_r ? 32'h0000_0001 : 32'h0000_00F0;
	end
	// Line 4 raised on request; line 0 always pending but outside the entry mask
	always_comb begin
		irq_pending = fire ? 32'h0000_0011 : 32'h0000_0001;
	end
endmodule // core_model

// ===== verification/test_clock_power_wake_sequencer.sv
// Self-checking bench for the clock, power and wake sequencer
`timescale 1ns/1ps
module test_clock_power_wake_sequencer;
	// Stimulus, changed at the falling edge
	reg sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, main_loop_en = 1'b0, alt_loop_en = 1'b0, fire = 1'b0;
	reg main_loop_lock = 1'b0, alt_loop_lock = 1'b1, main_loop_ref_osc = 1'b0, rtc_1hz_in = 1'b0, rtc_32k_in = 1'b0;
	reg wdog_osc_in = 1'b1, wdog_enable = 1'b0, sleep_enter = 1'b0, keep_32k_in_dpd = 1'b0, irc_was_source = 1'b0;
	reg rtc_alarm = 1'b0;
	reg [7:0] main_loop_out_div = 8'h00, alt_loop_out_div = 8'h05, derived_div = 8'h04;
	reg [1:0] clock_source_select = 2'h0, clock_output_select = 2'h3, sleep_mode = 2'h0;
	reg [31:0] periph_power_req = 32'h0000_00A5;
	wire [31:0] wake_mask_in, irq_pending, periph_power_r;
	wire [7:0] main_loop_div_r, alt_loop_div_r;
	wire [1:0] src_active_r;
	wire main_loop_power_r, alt_loop_power_r, main_loop_ref_osc_r, derived_tick_r, clock_output_pin_r, rtc_1hz_r;
	wire wdog_osc_run_r, core_power_r, osc32k_power_r, clocks_stopped_r, cpu_resume_r, flash_ready_r, wake_event_r;
	integer bad_count = 0, compares = 0, n, i;
	// One MHz figures keep wake and flash counts short
	clock_power_wake_sequencer #(.CLK_MHZ(1)) i_clock_power_wake_sequencer (
		.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
		.main_loop_en(main_loop_en), .alt_loop_en(alt_loop_en),
		.main_loop_lock(main_loop_lock), .alt_loop_lock(alt_loop_lock),
		.main_loop_ref_osc(main_loop_ref_osc), .main_loop_out_div(main_loop_out_div),
		.alt_loop_out_div(alt_loop_out_div), .clock_source_select(clock_source_select),
		.derived_div(derived_div), .clock_output_select(clock_output_select),
		.rtc_1hz_in(rtc_1hz_in), .rtc_32k_in(rtc_32k_in), .wdog_osc_in(wdog_osc_in),
		.wdog_enable(wdog_enable), .periph_power_req(periph_power_req),
		.sleep_mode(sleep_mode), .sleep_enter(sleep_enter), .keep_32k_in_dpd(keep_32k_in_dpd),
		.irc_was_source(irc_was_source), .wake_mask_in(wake_mask_in), .irq_pending(irq_pending),
		.rtc_alarm(rtc_alarm),
		.main_loop_power_r(main_loop_power_r), .alt_loop_power_r(alt_loop_power_r),
		.main_loop_ref_osc_r(main_loop_ref_osc_r), .main_loop_div_r(main_loop_div_r),
		.alt_loop_div_r(alt_loop_div_r), .src_active_r(src_active_r), .derived_tick_r(derived_tick_r),
		.clock_output_pin_r(clock_output_pin_r), .rtc_1hz_r(rtc_1hz_r), .wdog_osc_run_r(wdog_osc_run_r),
		.periph_power_r(periph_power_r), .core_power_r(core_power_r), .osc32k_power_r(osc32k_power_r),
		.clocks_stopped_r(clocks_stopped_r), .cpu_resume_r(cpu_resume_r), .flash_ready_r(flash_ready_r),
		.wake_event_r(wake_event_r)
	);
	core_model i_core_model (
		.sys_clk(sys_clk),
		.clocks_stopped_r(clocks_stopped_r),
		.fire(fire),
		.wake_mask_in(wake_mask_in),
		.irq_pending(irq_pending)
	);
	always #5 sys_clk = ~sys_clk;
	// Compare and count
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("Error at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task give_verdict;
		begin
			if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
			else $display("RESULT: FAIL");
			$finish;
		end
	endtask
	task cyc(input integer k);
		repeat (k) @(negedge sys_clk);
	endtask
	// Bounded wait: sel 0 resume, 1 flash ready; n gives cycles
	task wt(input integer sel, input integer lim);
		begin
			n = 0;
			while ((sel ? flash_ready_r : cpu_resume_r) !== 1'b1 && n < lim) begin
				cyc(1);
				n = n + 1;
			end
			// A wait that runs out counts as a mismatch; the run goes on to the verdict
			if ((sel ? flash_ready_r : cpu_resume_r) !== 1'b1) begin
				$display("Error at %0t: wait ran out", $time);
				bad_count = bad_count + 1;
			end
		end
	endtask
	// One-cycle entry strobe, then stopped state
	task sleep(input [1:0] m);
		begin
			sleep_mode = m;
			sleep_enter = 1'b1;
			cyc(1);
			sleep_enter = 1'b0;
			cyc(1);
			chk({clocks_stopped_r, cpu_resume_r}, 2);
		end
	endtask
	initial begin
		cyc(16);
		rst_n = 1'b1;
		cyc(1);
		chk({main_loop_power_r, alt_loop_power_r}, 0);
		chk({main_loop_div_r, alt_loop_div_r}, 16'h0205);
		main_loop_en = 1'b1;
		alt_loop_en = 1'b1;
		main_loop_ref_osc = 1'b1;
		clock_source_select = 2'h2;
		cyc(4);
		chk(src_active_r, 0);
		chk({main_loop_power_r, alt_loop_power_r, main_loop_ref_osc_r}, 7);
		main_loop_lock = 1'b1;
		cyc(4);
		chk(src_active_r, 2);
		clock_source_select = 2'h3;
		cyc(2);
		chk(src_active_r, 3);
		alt_loop_lock = 1'b0;
		cyc(2);
		chk(src_active_r, 0);
		clock_source_select = 2'h1;
		cyc(2);
		chk(src_active_r, 1);
		clock_source_select = 2'h0;
		clock_output_select = 2'h0;
		cyc(4);
		n = 0;
		for (i = 0; i < 40; i = i + 1) begin
			cyc(1);
			n = n + derived_tick_r + clock_output_pin_r;
		end
		chk(n, 20);
		rtc_32k_in = 1'b1;
		rtc_1hz_in = 1'b1;
		wdog_enable = 1'b1;
		clock_output_select = 2'h1;
		cyc(2);
		chk({clock_output_pin_r, rtc_1hz_r, wdog_osc_run_r}, 7);
		rtc_32k_in = 1'b0;
		clock_output_select = 2'h2;
		cyc(2);
		chk(clock_output_pin_r, 1);
		chk(periph_power_r, 32'h0000_00A5);
		wdog_enable = 1'b0;
		cyc(2);
		chk({clock_output_pin_r, wdog_osc_run_r}, 0);
		sleep(2'h1);
		chk({main_loop_power_r, flash_ready_r}, 1);
		fire = 1'b1;
		wt(0, 20);
		fire = 1'b0;
		chk(n < 8, 1);
		irc_was_source = 1'b1;
		cyc(2);
		sleep(2'h2);
		chk(flash_ready_r, 0);
		fire = 1'b1;
		wt(0, 200);
		fire = 1'b0;
		chk(n >= 64 && n <= 70, 1);
		chk(flash_ready_r, 0);
		wt(1, 200);
		chk(n >= 30 && n <= 40, 1);
		clock_source_select = 2'h2;
		keep_32k_in_dpd = 1'b1;
		cyc(4);
		chk(src_active_r, 2);
		sleep(2'h3);
		chk(periph_power_r, 32'h0000_0000);
		chk({core_power_r, osc32k_power_r}, 1);
		fire = 1'b1;
		cyc(10);
		chk(cpu_resume_r, 0);
		fire = 1'b0;
		rtc_alarm = 1'b1;
		cyc(1);
		rtc_alarm = 1'b0;
		wt(0, 200);
		chk(n >= 60, 1);
		chk(flash_ready_r, 0);
		// Second deep power-down, left by the reset pin this time
		sleep(2'h3);
		rst_n = 1'b0;
		cyc(2);
		rst_n = 1'b1;
		cyc(2);
		chk({core_power_r, clocks_stopped_r, cpu_resume_r, flash_ready_r}, 4'hB);
		give_verdict;
	end
endmodule // test_clock_power_wake_sequencer
